//--- verilog/ssf_pkg.sv
// package for the spi status flag block: offsets, fields, reset values, timing
// assumes a 25 MHz hclk and word-aligned register slots on AHB-Lite
package ssf_pkg;

   // ------------------------------------------------------------
   // register indices; byte address is four times the index
   // ------------------------------------------------------------
   localparam logic [9:0] SSF_IDX_STATUS = 10'h0ea;
   localparam logic [9:0] SSF_IDX_CTRL = 10'h0f0;
   localparam logic [9:0] SSF_IDX_RXDATA = 10'h0f1;
   localparam logic [9:0] SSF_IDX_TXDATA = 10'h0f2;
   localparam logic [9:0] SSF_IDX_MASK = 10'h0f3;

   // ------------------------------------------------------------
   // status and mask field positions
   // ------------------------------------------------------------
   localparam int SSF_ST_BUSY = 7;
   localparam int SSF_ST_MULTI_MASTER_ERROR_FLAG = 6;
   localparam int SSF_ST_RXOF = 5;
   localparam int SSF_ST_RXIRQ = 4;

   // ------------------------------------------------------------
   // control field positions
   // ------------------------------------------------------------
   localparam int SSF_CT_MODE = 0;
   localparam int SSF_CT_OVWR = 1;
   localparam int SSF_CT_MASTER = 2;
   localparam int SSF_CT_SSIN = 3;
   localparam int SSF_CT_W = 4;

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [3:0] SSF_CTRL_RST = 4'h0;
   localparam logic [2:0] SSF_MASK_RST = 3'h0;
   localparam logic [7:0] SSF_BYTE_RST = 8'h00;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int SSF_CLK_NS = 40;
   localparam int SSF_SCLK_HALF_NS = 160;
   localparam int SSF_SCLK_HALF_CYC = (SSF_SCLK_HALF_NS + SSF_CLK_NS - 1) / SSF_CLK_NS;
   localparam int SSF_BITS = 8;

endpackage

//--- verilog/ssf_link_if.sv
// link between the register side and the serial engine
// assumes both ends run on hclk
`timescale 1ns/1ps
interface ssf_link_if;
   logic start;
   logic [7:0] tx_byte;
   logic master;
   logic ss_in_en;
   logic busy;
   logic done;
   logic [7:0] rx_byte;
   logic ss_low;

   modport ctl
   (
      output start, tx_byte, master, ss_in_en,
      input busy, done, rx_byte, ss_low
   );

   modport eng
   (
      input start, tx_byte, master, ss_in_en,
      output busy, done, rx_byte, ss_low
   );
endinterface

//--- verilog/ssf_engine.sv
// serial byte engine: master clock generation, slave sampling, pin drive
// assumes pins arrive asynchronous to hclk; mode 0 clocking (idle low, sample on rise)
`timescale 1ns/1ps
module ssf_engine #(
   parameter int HALF_CYC = ssf_pkg::SSF_SCLK_HALF_CYC
)
(
   input wire logic hclk,
   input wire logic hresetn,
   ssf_link_if.eng lnk,
   input wire logic sclk_i,
   output logic sclk_o,
   output logic sclk_oe,
   input wire logic mosi_i,
   output logic mosi_o,
   output logic mosi_oe,
   input wire logic miso_i,
   output logic miso_o,
   output logic miso_oe,
   input wire logic ss_i,
   output logic ss_o,
   output logic ss_oe
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef enum logic [1:0] {SSF_IDLE, SSF_MSHIFT, SSF_SSHIFT} ssf_eng_st_t;

   typedef struct packed {
      ssf_eng_st_t st;
      logic sclk_s1;
      logic sclk_s2;
      logic sclk_s3;
      logic ss_s1;
      logic ss_s2;
      logic mosi_s1;
      logic mosi_s2;
      logic miso_s1;
      logic miso_s2;
      logic [2:0] bitcnt;
      logic [7:0] shreg;
      logic [7:0] div;
      logic sclk_o;
      logic sclk_oe;
      logic mosi_o;
      logic mosi_oe;
      logic miso_o;
      logic miso_oe;
      logic ss_o;
      logic ss_oe;
      logic busy;
      logic done;
      logic [7:0] rx_byte;
   } ssf_eng_t;

   localparam logic [7:0] DIV_LAST = 8'(HALF_CYC - 1);

   // elaboration check: the divider counts in eight bits
   if (HALF_CYC < 1 || HALF_CYC > 256)
   begin
      $error("HALF_CYC out of range");
   end

   ssf_eng_t q;
   ssf_eng_t next_q;
   logic rise;
   logic fall;
   logic ss_low;

   assign rise = q.sclk_s2 & ~q.sclk_s3;
   assign fall = ~q.sclk_s2 & q.sclk_s3;
   assign ss_low = ~q.ss_s2;

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb
   begin
      next_q = q;
      next_q.sclk_s1 = sclk_i;
      next_q.sclk_s2 = q.sclk_s1;
      next_q.sclk_s3 = q.sclk_s2;
      next_q.ss_s1 = ss_i;
      next_q.ss_s2 = q.ss_s1;
      next_q.mosi_s1 = mosi_i;
      next_q.mosi_s2 = q.mosi_s1;
      next_q.miso_s1 = miso_i;
      next_q.miso_s2 = q.miso_s1;
      next_q.done = 1'b0;
      next_q.sclk_oe = lnk.master;
      next_q.mosi_oe = lnk.master;
      next_q.ss_oe = lnk.master & ~lnk.ss_in_en;
      next_q.miso_oe = ~lnk.master & ss_low;
      unique case (q.st)
         SSF_IDLE:
         begin
            next_q.busy = 1'b0;
            next_q.ss_o = 1'b1;
            next_q.sclk_o = 1'b0;
            if (lnk.master && lnk.start)
            begin
               next_q.st = SSF_MSHIFT;
               next_q.shreg = lnk.tx_byte;
               next_q.mosi_o = lnk.tx_byte[7];
               next_q.div = 8'h00;
               next_q.bitcnt = 3'h0;
               next_q.busy = 1'b1;
               next_q.ss_o = 1'b0;
            end
            else if (!lnk.master && ss_low)
            begin
               next_q.st = SSF_SSHIFT;
               next_q.shreg = lnk.tx_byte;
               next_q.miso_o = lnk.tx_byte[7];
               next_q.bitcnt = 3'h0;
               next_q.busy = 1'b1;
            end
         end
         SSF_MSHIFT:
         begin
            if (q.div == DIV_LAST)
            begin
               next_q.div = 8'h00;
               next_q.sclk_o = ~q.sclk_o;
               if (!q.sclk_o)
               begin
                  next_q.shreg = {q.shreg[6:0], q.miso_s2};
               end
               else if (q.bitcnt == 3'h7)
               begin
                  // byte complete: release select and go idle
                  next_q.done = 1'b1;
                  next_q.rx_byte = q.shreg;
                  next_q.st = SSF_IDLE;
                  next_q.busy = 1'b0;
                  next_q.ss_o = 1'b1;
               end
               else
               begin
                  next_q.bitcnt = q.bitcnt + 3'h1;
                  next_q.mosi_o = q.shreg[7];
               end
            end
            else
            begin
               next_q.div = q.div + 8'h01;
            end
         end
         SSF_SSHIFT:
         begin
            if (!ss_low || lnk.master)
            begin
               next_q.st = SSF_IDLE;
               next_q.busy = 1'b0;
            end
            else if (rise)
            begin
               next_q.bitcnt = q.bitcnt + 3'h1;
               next_q.shreg = {q.shreg[6:0], q.mosi_s2};
               if (q.bitcnt == 3'h7)
               begin
                  next_q.done = 1'b1;
                  next_q.rx_byte = {q.shreg[6:0], q.mosi_s2};
                  next_q.shreg = lnk.tx_byte;
               end
            end
            else if (fall)
            begin
               next_q.miso_o = q.shreg[7];
            end
         end
      endcase
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         q <= '{st: SSF_IDLE, sclk_s1: 1'b0, sclk_s2: 1'b0, sclk_s3: 1'b0,
                ss_s1: 1'b1, ss_s2: 1'b1, ss_o: 1'b1, default: '0};
      end
      else
      begin
         q <= next_q;
      end
   end

   assign lnk.busy = q.busy;
   assign lnk.done = q.done;
   assign lnk.rx_byte = q.rx_byte;
   assign lnk.ss_low = ~q.ss_s2;
   assign sclk_o = q.sclk_o;
   assign sclk_oe = q.sclk_oe;
   assign mosi_o = q.mosi_o;
   assign mosi_oe = q.mosi_oe;
   assign miso_o = q.miso_o;
   assign miso_oe = q.miso_oe;
   assign ss_o = q.ss_o;
   assign ss_oe = q.ss_oe;

endmodule

//--- verilog/ssf_top.sv
// spi status flag block: AHB-Lite registers, receive flags, interrupt, engine
// assumes a single AHB-Lite master and pins asynchronous to hclk
//
// What this block does
// - status bit 7 reads 1 while a byte moves, master or slave, else 0.
// - multi-master error bit 6 sets when select input enabled and driven low mid-master.
// - overflow bit 5 sets if received data unread when next byte ends; read clears.
// - with overwrite enabled, an overflowing byte replaces the held received data.
// - receive flag bit 4 sets on new received data; reading received data clears it.
// - mode 0 with interrupt enabled raises the interrupt whenever receive flag sets.
// - in mode 0 a transfer waits for a receive read, not for the received register to empty; select released.
// - mode 0 starts a transfer on receive read; mode 1 on transmit write.
`timescale 1ns/1ps
module ssf_top #(
   parameter int HALF_CYC = ssf_pkg::SSF_SCLK_HALF_CYC
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   output logic irq,
   input wire logic sclk_i,
   output logic sclk_o,
   output logic sclk_oe,
   input wire logic mosi_i,
   output logic mosi_o,
   output logic mosi_oe,
   input wire logic miso_i,
   output logic miso_o,
   output logic miso_oe,
   input wire logic ss_i,
   output logic ss_o,
   output logic ss_oe
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      logic pend;
      logic wr;
      logic [9:0] idx;
      logic hreadyout;
      logic [31:0] hrdata;
      logic [ssf_pkg::SSF_CT_W-1:0] ctrl;
      logic [2:0] mask;
      logic [7:0] tx;
      logic [7:0] rx;
      logic rx_full;
      logic multi_master_error_flag;
      logic rxof;
      logic rxirq;
      logic start_req;
      logic start;
      logic irq;
   } ssf_top_t;

   ssf_top_t q;
   ssf_top_t next_q;
   ssf_link_if lnk();

   logic acc;
   logic rd_rx;
   logic wr_tx;
   logic [2:0] clr;
   logic mm_ev;
   logic ov_ev;
   logic req_ev;
   logic mode1;
   logic master;
   logic [7:0] status;

   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   assign acc = hsel & htrans[1] & hready;
   assign rd_rx = q.pend & ~q.wr & (q.idx == ssf_pkg::SSF_IDX_RXDATA);
   assign wr_tx = q.pend & q.wr & (q.idx == ssf_pkg::SSF_IDX_TXDATA);
   assign clr = (q.pend && q.wr && q.idx == ssf_pkg::SSF_IDX_STATUS) ? hwdata[6:4] : 3'h0;
   assign mode1 = q.ctrl[ssf_pkg::SSF_CT_MODE];
   assign master = q.ctrl[ssf_pkg::SSF_CT_MASTER];
   assign mm_ev = master & q.ctrl[ssf_pkg::SSF_CT_SSIN] & lnk.busy & lnk.ss_low;
   assign ov_ev = lnk.done & q.rx_full & ~rd_rx;
   assign req_ev = master & ((~mode1 & rd_rx) | (mode1 & wr_tx));
   assign status = {lnk.busy, q.multi_master_error_flag, q.rxof, q.rxirq, 4'h0};

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb
   begin
      next_q = q;
      next_q.start = 1'b0;
      if (acc)
      begin
         next_q.pend = 1'b1;
         next_q.wr = hwrite;
         next_q.idx = haddr[11:2];
         next_q.hreadyout = 1'b0;
      end
      if (q.pend)
      begin
         next_q.pend = 1'b0;
         next_q.hreadyout = 1'b1;
         if (q.wr)
         begin
            unique case (q.idx)
               ssf_pkg::SSF_IDX_CTRL: next_q.ctrl = hwdata[ssf_pkg::SSF_CT_W-1:0];
               ssf_pkg::SSF_IDX_TXDATA: next_q.tx = hwdata[7:0];
               ssf_pkg::SSF_IDX_MASK: next_q.mask = hwdata[6:4];
               default: next_q.tx = q.tx;
            endcase
         end
         else
         begin
            unique case (q.idx)
               ssf_pkg::SSF_IDX_STATUS: next_q.hrdata = {24'h0, status};
               ssf_pkg::SSF_IDX_CTRL: next_q.hrdata = {28'h0, q.ctrl};
               ssf_pkg::SSF_IDX_RXDATA: next_q.hrdata = {24'h0, q.rx};
               ssf_pkg::SSF_IDX_TXDATA: next_q.hrdata = {24'h0, q.tx};
               ssf_pkg::SSF_IDX_MASK: next_q.hrdata = {25'h0, q.mask, 4'h0};
               default: next_q.hrdata = 32'h0;
            endcase
         end
      end

      // receive data capture
      if (lnk.done && (!q.rx_full || rd_rx || q.ctrl[ssf_pkg::SSF_CT_OVWR]))
      begin
         next_q.rx = lnk.rx_byte;
      end
      next_q.rx_full = (q.rx_full & ~rd_rx) | lnk.done;

      // sticky flags, set wins over clear
      next_q.multi_master_error_flag = (q.multi_master_error_flag & ~clr[2]) | mm_ev;
      next_q.rxof = (q.rxof & ~rd_rx & ~clr[1]) | ov_ev;
      next_q.rxirq = (q.rxirq & ~rd_rx & ~clr[0]) | lnk.done;

      // transfer launch; no launch without a read in mode 0
      next_q.start_req = (q.start_req | req_ev) & master;
      if (q.start_req && master && !lnk.busy && !q.start)
      begin
         next_q.start = 1'b1;
         next_q.start_req = req_ev;
      end

      // receive flag interrupts only in mode 0
      next_q.irq = |({q.multi_master_error_flag, q.rxof, q.rxirq & ~mode1} & q.mask);
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         q <= '{hreadyout: 1'b1, ctrl: ssf_pkg::SSF_CTRL_RST, mask: ssf_pkg::SSF_MASK_RST,
                tx: ssf_pkg::SSF_BYTE_RST, rx: ssf_pkg::SSF_BYTE_RST, default: '0};
      end
      else
      begin
         q <= next_q;
      end
   end

   // ------------------------------------------------------------
   // link and engine
   // ------------------------------------------------------------
   assign lnk.start = q.start;
   assign lnk.tx_byte = q.tx;
   assign lnk.master = master;
   assign lnk.ss_in_en = q.ctrl[ssf_pkg::SSF_CT_SSIN];

   ssf_engine #(
      .HALF_CYC(HALF_CYC)
   ) u_eng
   (
      .hclk(hclk),
      .hresetn(hresetn),
      .lnk(lnk),
      .sclk_i(sclk_i),
      .sclk_o(sclk_o),
      .sclk_oe(sclk_oe),
      .mosi_i(mosi_i),
      .mosi_o(mosi_o),
      .mosi_oe(mosi_oe),
      .miso_i(miso_i),
      .miso_o(miso_o),
      .miso_oe(miso_oe),
      .ss_i(ss_i),
      .ss_o(ss_o),
      .ss_oe(ss_oe)
   );

   assign hreadyout = q.hreadyout;
   assign hrdata = q.hrdata;
   assign hresp = 1'b0;
   assign irq = q.irq;

endmodule

//--- dv/ssf_top_checker.sv
// checker for the spi status flag block, top ports only
// assumes a bind onto ssf_top and a single hclk domain
`timescale 1ns/1ps
module ssf_top_checker #(
   parameter int HALF_CYC = 4
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic [31:0] hrdata,
   input wire logic hresp,
   input wire logic irq,
   input wire logic sclk_o,
   input wire logic sclk_oe,
   input wire logic mosi_oe,
   input wire logic miso_oe,
   input wire logic ss_o,
   input wire logic ss_oe
);
   // master frame: sixteen serial half periods from select fall to rise
   localparam int FR_MIN = 16 * HALF_CYC - 1;
   localparam int FR_MAX = 16 * HALF_CYC + 1;
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   // ---
   // bus and pin relations
   // ---
   bus_wait_a: assert property (hsel && htrans[1] && hready |=> !hreadyout ##1 hreadyout)
      else $error("bus wait state wrong");
   resp_okay_a: assert property (hresp == 1'b0)
      else $error("bus response not okay");
   read_upper_a: assert property (hrdata[31:8] == 24'h000000)
      else $error("read data upper bits set");
   pin_dir_a: assert property (sclk_oe == mosi_oe && !(miso_oe && sclk_oe))
      else $error("pin directions disagree");
   sel_drive_a: assert property (ss_oe |-> sclk_oe)
      else $error("select driven outside master");
   frame_end_a: assert property ($fell(ss_o) && ss_oe |-> ##[FR_MIN:FR_MAX] $rose(ss_o))
      else $error("master frame length wrong");
   clk_idle_a: assert property (ss_o && ss_oe |-> !sclk_o)
      else $error("serial clock moves while deselected");
   stop_gap_a: assert property ($rose(ss_o) && ss_oe |=> ss_o [*4])
      else $error("select reasserted at once");
   frame_c: cover property ($fell(ss_o) && ss_oe);
   irq_c: cover property ($rose(irq));
   slave_c: cover property ($rose(miso_oe));
endmodule

bind ssf_top ssf_top_checker #(.HALF_CYC(HALF_CYC)) u_chk
(
   .hclk(hclk),
   .hresetn(hresetn),
   .hsel(hsel),
   .htrans(htrans),
   .hready(hready),
   .hreadyout(hreadyout),
   .hrdata(hrdata),
   .hresp(hresp),
   .irq(irq),
   .sclk_o(sclk_o),
   .sclk_oe(sclk_oe),
   .mosi_oe(mosi_oe),
   .miso_oe(miso_oe),
   .ss_o(ss_o),
   .ss_oe(ss_oe)
);

//--- dv/ssf_peer.sv
// far-side spi device: answers as slave, or sends a byte as master
// assumes the bench resolves each pin from the block's output enable alone
`timescale 1ns/1ps
module ssf_peer (
   input wire logic sclk_w,
   input wire logic ss_w,
   input wire logic mosi_w,
   input wire logic miso_w,
   input wire logic hold_sel,
   input wire logic [7:0] reply,
   output logic [7:0] got,
   output logic miso_d,
   output logic sclk_d,
   output logic ss_d,
   output logic mosi_d
);
   logic [7:0] sh = 8'h00;
   logic ss_m = 1'b1;
   logic mst = 1'b0;
   assign ss_d = ss_m & ~hold_sel;
   initial
   begin
      got = 8'h00;
      miso_d = 1'b0;
      sclk_d = 1'b0;
      mosi_d = 1'b0;
   end
   // slave role, msb first; released line shows the inverse
   always @(negedge ss_w)
   begin
      sh = reply;
      miso_d = reply[7];
   end
   always @(posedge ss_w) miso_d = ~miso_d;
   always @(posedge sclk_w) if (!ss_w && !mst) got = {got[6:0], mosi_w};
   always @(negedge sclk_w)
   begin
      if (!ss_w && !mst)
      begin
         sh = {sh[6:0], 1'b0};
         miso_d = sh[7];
      end
   end
   // master role at a 320 ns serial period
   task automatic send(input logic [7:0] b);
      #7 mst = 1'b1;
      ss_m = 1'b0;
      #320;
      for (int i = 7; i >= 0; i--)
      begin
         mosi_d = b[i];
         #160 sclk_d = 1'b1;
         got = {got[6:0], miso_w};
         #160 sclk_d = 1'b0;
      end
      #160 ss_m = 1'b1;
      mosi_d = ~mosi_d;
      mst = 1'b0;
   endtask
endmodule

//--- dv/ssf_top_tb.sv
// self-checking bench for the spi status flag block
// assumes ssf_peer on the pins and one AHB-Lite master in tasks
`timescale 1ns/1ps
module ssf_top_tb;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel, hwrite, hreadyout, hresp, irq;
   logic rd_pend = 1'b0;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata;
   logic sclk_i, sclk_o, sclk_oe, mosi_i, mosi_o, mosi_oe;
   logic miso_i, miso_o, miso_oe, ss_i, ss_o, ss_oe;
   logic sclk_d, mosi_d, miso_d, ss_d, hold_sel;
   logic [7:0] reply, got, seed, a, b;
   logic [31:0] exp_q[$];
   int failures = 0;
   int comparisons = 0;
   int cycles = 0;
   always #20 hclk = ~hclk;
   assign sclk_i = sclk_oe ? sclk_o : sclk_d;
   assign mosi_i = mosi_oe ? mosi_o : mosi_d;
   assign miso_i = miso_oe ? miso_o : miso_d;
   assign ss_i = ss_oe ? ss_o : ss_d;
   ssf_top #(.HALF_CYC(4)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .irq(irq), .sclk_i(sclk_i),
      .sclk_o(sclk_o), .sclk_oe(sclk_oe), .mosi_i(mosi_i), .mosi_o(mosi_o), .mosi_oe(mosi_oe),
      .miso_i(miso_i), .miso_o(miso_o), .miso_oe(miso_oe), .ss_i(ss_i), .ss_o(ss_o),
      .ss_oe(ss_oe));
   ssf_peer peer (.sclk_w(sclk_i), .ss_w(ss_i), .mosi_w(mosi_i), .miso_w(miso_i),
      .hold_sel(hold_sel), .reply(reply), .got(got), .miso_d(miso_d), .sclk_d(sclk_d),
      .ss_d(ss_d), .mosi_d(mosi_d));
   // ---
   // helpers
   // ---
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic give_verdict();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e)
      begin
         failures++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic bus(input logic w, input logic [9:0] idx, input logic [31:0] d);
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {20'h0, idx, 2'h0};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
   endtask
   task automatic wr(input logic [9:0] idx, input logic [31:0] d);
      bus(1'b1, idx, d);
   endtask
   task automatic rd(input logic [9:0] idx, input logic [31:0] e);
      exp_q.push_back(e);
      bus(1'b0, idx, 32'h0);
   endtask
   task automatic st(input logic [31:0] e);
      rd(ssf_pkg::SSF_IDX_STATUS, e);
   endtask
   task automatic xfer(input logic [7:0] d);
      reply = d;
      seed = lfsr(seed);
      wr(ssf_pkg::SSF_IDX_TXDATA, {24'h0, seed});
      @(posedge ss_o);
      repeat (4) @(posedge hclk);
      chk("mosi", {24'h0, seed}, {24'h0, got});
   endtask
   // read results and timeout
   always @(posedge hclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         failures++;
         give_verdict();
      end
      if (rd_pend && hreadyout)
      begin
         rd_pend <= 1'b0;
         chk("hrdata", exp_q.pop_front(), hrdata);
      end
      else if (htrans[1] && hreadyout && !hwrite)
         rd_pend <= 1'b1;
   end
   // ---
   // scenarios
   // ---
   initial
   begin
      hsel = 1'b1;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      haddr = 32'h0;
      hwdata = 32'h0;
      hold_sel = 1'b0;
      reply = 8'h00;
      seed = 8'h21;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      st(32'h0);
      rd(10'h000, 32'h0);
      rd(ssf_pkg::SSF_IDX_MASK, 32'h0);
      wr(ssf_pkg::SSF_IDX_MASK, 32'h70);
      wr(ssf_pkg::SSF_IDX_CTRL, 32'h4);
      a = lfsr(seed);
      reply = a;
      rd(ssf_pkg::SSF_IDX_RXDATA, 32'h0);
      @(negedge ss_o);
      st(32'h80);
      @(posedge ss_o);
      repeat (4) @(posedge hclk);
      chk("irq", 32'h1, {31'h0, irq});
      st(32'h10);
      b = lfsr(a);
      reply = b;
      rd(ssf_pkg::SSF_IDX_RXDATA, {24'h0, a});
      @(posedge ss_o);
      wr(ssf_pkg::SSF_IDX_TXDATA, 32'h33);
      repeat (30) @(posedge hclk);
      chk("ss_o", 32'h1, {31'h0, ss_o});
      st(32'h10);
      wr(ssf_pkg::SSF_IDX_CTRL, 32'h5);
      repeat (2) @(posedge hclk);
      chk("irq", 32'h0, {31'h0, irq});
      rd(ssf_pkg::SSF_IDX_RXDATA, {24'h0, b});
      for (int k = 0; k < 2; k++)
      begin
         wr(ssf_pkg::SSF_IDX_CTRL, k ? 32'h7 : 32'h5);
         a = lfsr(seed);
         xfer(a);
         b = lfsr(a);
         xfer(b);
         st(32'h30);
         chk("irq", 32'h1, {31'h0, irq});
         rd(ssf_pkg::SSF_IDX_RXDATA, {24'h0, k ? b : a});
         st(32'h0);
      end
      a = lfsr(seed);
      reply = a;
      hold_sel <= 1'b1;
      wr(ssf_pkg::SSF_IDX_CTRL, 32'hd);
      xfer(a);
      hold_sel <= 1'b0;
      st(32'h50);
      chk("irq", 32'h1, {31'h0, irq});
      wr(ssf_pkg::SSF_IDX_STATUS, 32'h40);
      st(32'h10);
      rd(ssf_pkg::SSF_IDX_RXDATA, {24'h0, a});
      wr(ssf_pkg::SSF_IDX_CTRL, 32'h0);
      seed = lfsr(seed);
      wr(ssf_pkg::SSF_IDX_TXDATA, {24'h0, seed});
      a = lfsr(seed);
      fork
         peer.send(a);
         begin
            repeat (12) @(posedge hclk);
            st(32'h80);
         end
      join
      repeat (6) @(posedge hclk);
      st(32'h10);
      chk("irq", 32'h1, {31'h0, irq});
      rd(ssf_pkg::SSF_IDX_RXDATA, {24'h0, a});
      chk("miso", {24'h0, seed}, {24'h0, got});
      repeat (4) @(posedge hclk);
      give_verdict();
   end
endmodule
